// ===== src/awce_pkg.sv
// shared constants for the ata write command engine, both ends
package awce_pkg;
	// task-file offsets
	localparam logic [2:0] TF_FEAT = 3'h1;
	localparam logic [2:0] TF_CNT  = 3'h2;
	localparam logic [2:0] TF_SNUM = 3'h3;
	localparam logic [2:0] TF_CYLL = 3'h4;
	localparam logic [2:0] TF_CYLH = 3'h5;
	localparam logic [2:0] TF_DH   = 3'h6;
	localparam logic [2:0] TF_CMD  = 3'h7;
	// opcodes
	localparam logic [7:0] OP_WS_A   = 8'h30;
	localparam logic [7:0] OP_WS_B   = 8'h31;
	localparam logic [7:0] OP_LONG_A = 8'h32;
	localparam logic [7:0] OP_LONG_B = 8'h33;
	localparam logic [7:0] OP_WS_NE  = 8'h38;
	localparam logic [7:0] OP_WVER   = 8'h3c;
	localparam logic [7:0] OP_WM     = 8'hc5;
	localparam logic [7:0] OP_WM_NE  = 8'hcd;
	// sector geometry
	localparam int         SECT_BYTES = 512;
	localparam int         ECC_BYTES  = 4;
	localparam int         LONG_BYTES = SECT_BYTES + ECC_BYTES;
	localparam int         SECT_WORDS = SECT_BYTES / 2;
	localparam logic [8:0] LAST_WORD  = 9'(SECT_WORDS - 1);
	localparam logic [8:0] LAST_LONG  = 9'(SECT_WORDS + ECC_BYTES - 1);
	localparam logic [8:0] MAX_SECT   = 9'h100;
	localparam logic [8:0] ONE_SECT   = 9'h001;
	localparam int         DH_LBA_BIT = 6;
	// busy must rise this soon after a block-mode command
	localparam int         CLK_NS      = 40;
	localparam int         BUSY_MAX_NS = 400;
	localparam int         BUSY_MAX_CYC = BUSY_MAX_NS / CLK_NS;
endpackage : awce_pkg

// ===== src/awce_if.sv
// task-file and pio data link between host and device
`timescale 1ns/1ps
interface awce_if;
	logic        tf_wr;             // host: task-file write strobe
	logic [2:0]  tf_addr;           // host: task-file offset
	logic [7:0]  tf_wdata;          // host: task-file data
	logic        dat_wr;            // host: pio data strobe
	logic [15:0] dat_wdata;         // host: word, or ecc byte in [7:0]
	logic        st_rd;             // host: status read, clears intrq
	logic        busy_flag;         // dev: busy
	logic        data_request_flag; // dev: data request
	logic        err_flag;          // dev: error
	logic        abrt_flag;         // dev: aborted command
	logic        intrq;             // dev: interrupt request
	logic [7:0]  sec_cnt;           // dev: sector count / residual
	logic [7:0]  sec_num;           // dev: sector number
	logic [7:0]  cyl_lo;            // dev: cylinder low
	logic [7:0]  cyl_hi;            // dev: cylinder high
	logic [7:0]  drv_head;          // dev: drive/head
	modport dev (input tf_wr, tf_addr, tf_wdata, dat_wr, dat_wdata, st_rd,
		output busy_flag, data_request_flag, err_flag, abrt_flag, intrq,
		sec_cnt, sec_num, cyl_lo, cyl_hi, drv_head);
	modport host (output tf_wr, tf_addr, tf_wdata, dat_wr, dat_wdata, st_rd,
		input busy_flag, data_request_flag, err_flag, abrt_flag, intrq,
		sec_cnt, sec_num, cyl_lo, cyl_hi, drv_head);
endinterface : awce_if

// ===== src/awce_dev.sv
// device end: write-family command decode, sequencing and task file
// Notes on behaviour
// RULE1: long write moves one sector, 516 bytes
// RULE2: 512 bytes as words, then 4 ecc bytes
// RULE3: busy within 400 ns of block command
// RULE4: block mode interrupts once per block
// RULE5: host checks data request per block only
// RULE6: full blocks, then sector count modulo block
// RULE7: abort block write if unset or disabled
// RULE8: block count of one must work
// RULE9: block error stops at failing sector
// RULE10: residual count, address of failing sector
// RULE11: block write without erase skips erase
// RULE12: 1 to 256 sectors, zero means 256
// RULE13: busy, then data request and busy off
// RULE14: no interrupt before first data transfer
// RULE15: host sends nothing while busy
// RULE16: between sectors busy, then request plus interrupt
// RULE17: after last sector busy until done, interrupt
// RULE18: failing sector address stays in task file
// RULE19: write without erase skips implied erase
// RULE20: opcode 3ch verifies each sector after programming
// RULE21: 30h, 31h sector write; 38h without erase
// RULE22: c5h block write; cdh without erase
// RULE23: lba packing across address registers
// RULE24: 32h and 33h are long write
`timescale 1ns/1ps
module awce_dev
	import awce_pkg::*;
#(
	parameter int         SPT   = 63, // sectors per track, chs mode
	parameter logic [3:0] HEADS = 4'hf // highest head number, chs mode
) (
	input  wire logic        sys_clk,      // 25 mhz clock
	input  wire logic        nrst,         // async reset, active low
	awce_if.dev              bus,          // task-file link
	input  wire logic [7:0]  mult_size,    // block size, 0 = not set
	input  wire logic        mult_en,      // block-mode writes enabled
	output logic             med_req,      // pulse: program one sector
	output logic [27:0]      med_addr,     // sector address
	output logic             med_lba_mode, // med_addr is lba
	output logic             med_no_erase, // skip implied erase
	output logic             med_verify,   // verify after programming
	input  wire logic        med_done,     // pulse: sector finished
	input  wire logic        med_err,      // with med_done: failed
	output logic             wd_valid,     // pulse: data word out
	output logic [15:0]      wd_data       // data word
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_SETUP = 4'b0010,
		S_XFER  = 4'b0100,
		S_PROG  = 4'b1000
	} awce_dst_t;

	awce_dst_t   state_r;
	logic        busy_r;
	logic        drq_r;
	logic        err_r;
	logic        abrt_r;
	logic        intrq_r;
	logic        op_long_r;
	logic        op_blk_r;
	logic [8:0]  remain_r;
	logic [8:0]  blk_left_r;
	logic [8:0]  word_r;
	logic [7:0]  cnt_r;
	logic [7:0]  snum_r;
	logic [7:0]  cyll_r;
	logic [7:0]  cylh_r;
	logic [7:0]  dh_r;

	logic        cmd_take;
	logic        is_ws;
	logic        is_long;
	logic        is_blk;
	logic        blk_bad;
	logic        last_word;
	logic        sec_ok;
	logic        int_set;
	logic [8:0]  req_cnt;
	logic [8:0]  mult9;
	logic [8:0]  blk_first;
	logic [8:0]  blk_next;
	logic [8:0]  remain_m1;
	logic [27:0] cur_addr;
	logic [27:0] lba_inc;

	//////////////////////////////////////////////////////////////////////
	// decode
	assign cmd_take = bus.tf_wr && (bus.tf_addr == TF_CMD)
		&& (state_r == S_IDLE);
	assign is_ws = (bus.tf_wdata == OP_WS_A) || (bus.tf_wdata == OP_WS_B)
		|| (bus.tf_wdata == OP_WS_NE) || (bus.tf_wdata == OP_WVER); // RULE21 RULE20
	assign is_long = (bus.tf_wdata == OP_LONG_A)
		|| (bus.tf_wdata == OP_LONG_B); // RULE24
	assign is_blk = (bus.tf_wdata == OP_WM)
		|| (bus.tf_wdata == OP_WM_NE); // RULE22
	assign blk_bad = is_blk && ((mult_size == 8'h00) || !mult_en); // RULE7
	// a zero count asks for the full 256 sectors
	assign req_cnt = (cnt_r == 8'h00) ? MAX_SECT : {1'b0, cnt_r}; // RULE12
	assign mult9 = {1'b0, mult_size};
	assign remain_m1 = remain_r - ONE_SECT;
	// block size of one falls out naturally when mult_size is 1
	assign blk_first = !op_blk_r ? ONE_SECT
		: ((remain_r < mult9) ? remain_r : mult9); // RULE6 RULE8
	assign blk_next = !op_blk_r ? ONE_SECT
		: ((remain_m1 < mult9) ? remain_m1 : mult9); // RULE6
	// word mode for data, then byte-wide ecc on a long write
	assign last_word = op_long_r ? (word_r == LAST_LONG)
		: (word_r == LAST_WORD); // RULE1 RULE2
	assign sec_ok = (state_r == S_PROG) && med_done && !med_err;
	assign cur_addr = {dh_r[3:0], cylh_r, cyll_r, snum_r}; // RULE23
	assign lba_inc = cur_addr + 28'h0000001;

	//////////////////////////////////////////////////////////////////////
	// command sequencing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r    <= S_IDLE;
			busy_r     <= 1'b0;
			drq_r      <= 1'b0;
			err_r      <= 1'b0;
			abrt_r     <= 1'b0;
			op_long_r  <= 1'b0;
			op_blk_r   <= 1'b0;
			remain_r   <= 9'h000;
			blk_left_r <= 9'h000;
			word_r     <= 9'h000;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (cmd_take) begin
					if ((is_ws || is_long || is_blk) && !blk_bad) begin
						// busy one edge after the command, well inside 400 ns
						state_r   <= S_SETUP;
						busy_r    <= 1'b1; // RULE3 RULE13
						err_r     <= 1'b0;
						abrt_r    <= 1'b0;
						op_long_r <= is_long;
						op_blk_r  <= is_blk;
						remain_r  <= is_long ? ONE_SECT : req_cnt; // RULE1
					end else begin
						err_r  <= 1'b1; // RULE7
						abrt_r <= 1'b1;
					end
				end
			end
			S_SETUP: begin
				state_r    <= S_XFER;
				busy_r     <= 1'b0; // RULE13
				drq_r      <= 1'b1;
				blk_left_r <= blk_first;
				word_r     <= 9'h000;
			end
			S_XFER: begin
				if (bus.dat_wr) begin
					word_r <= word_r + 9'h001;
					if (last_word) begin
						state_r <= S_PROG;
						busy_r  <= 1'b1; // RULE16 RULE17
						drq_r   <= 1'b0;
					end
				end
			end
			S_PROG: begin
				if (med_done) begin
					if (med_err) begin
						// stop here, later sectors and blocks never move
						state_r <= S_IDLE; // RULE9 RULE18
						busy_r  <= 1'b0;
						err_r   <= 1'b1;
					end else if (remain_r == ONE_SECT) begin
						state_r <= S_IDLE; // RULE17
						busy_r  <= 1'b0;
						remain_r <= 9'h000;
					end else begin
						state_r  <= S_XFER; // RULE16
						busy_r   <= 1'b0;
						drq_r    <= 1'b1;
						word_r   <= 9'h000;
						remain_r <= remain_m1;
						blk_left_r <= (blk_left_r == ONE_SECT) ? blk_next
							: (blk_left_r - ONE_SECT);
					end
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// interrupt: aborts, errors, completion and each new block, but never
	// the first transfer; a status read in the same cycle loses to a set
	assign int_set = (cmd_take && !((is_ws || is_long || is_blk) && !blk_bad))
		|| ((state_r == S_PROG) && med_done
		&& (med_err || (remain_r == ONE_SECT)
		|| (blk_left_r == ONE_SECT))); // RULE4 RULE14 RULE16 RULE17

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			intrq_r <= 1'b0;
		end else begin
			intrq_r <= int_set || (intrq_r && !bus.st_rd);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// task file: host writes while idle, hardware advances on success so
	// an error leaves the failing address and the residual count
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r  <= 8'h00;
			snum_r <= 8'h00;
			cyll_r <= 8'h00;
			cylh_r <= 8'h00;
			dh_r   <= 8'h00;
		end else if (bus.tf_wr && (state_r == S_IDLE)) begin
			if (bus.tf_addr == TF_CNT) begin
				cnt_r <= bus.tf_wdata;
			end else if (bus.tf_addr == TF_SNUM) begin
				snum_r <= bus.tf_wdata;
			end else if (bus.tf_addr == TF_CYLL) begin
				cyll_r <= bus.tf_wdata;
			end else if (bus.tf_addr == TF_CYLH) begin
				cylh_r <= bus.tf_wdata;
			end else if (bus.tf_addr == TF_DH) begin
				dh_r <= bus.tf_wdata;
			end
		end else if (sec_ok) begin
			if (!op_long_r) begin
				cnt_r <= cnt_r - 8'h01; // RULE10
			end
			if (dh_r[DH_LBA_BIT]) begin
				{dh_r[3:0], cylh_r, cyll_r, snum_r} <= lba_inc; // RULE23
			end else if (snum_r == 8'(SPT)) begin
				snum_r <= 8'h01;
				if (dh_r[3:0] == HEADS) begin
					dh_r[3:0] <= 4'h0;
					{cylh_r, cyll_r} <= {cylh_r, cyll_r} + 16'h0001;
				end else begin
					dh_r[3:0] <= dh_r[3:0] + 4'h1;
				end
			end else begin
				snum_r <= snum_r + 8'h01;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// media side: host ecc bytes are dropped, media makes its own ecc
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			med_req      <= 1'b0;
			med_addr     <= 28'h0000000;
			med_lba_mode <= 1'b0;
			med_no_erase <= 1'b0;
			med_verify   <= 1'b0;
			wd_valid     <= 1'b0;
			wd_data      <= 16'h0000;
		end else begin
			med_req  <= (state_r == S_XFER) && bus.dat_wr && last_word;
			wd_valid <= (state_r == S_XFER) && bus.dat_wr
				&& (word_r <= LAST_WORD); // RULE2
			wd_data  <= bus.dat_wdata;
			med_addr <= cur_addr;
			med_lba_mode <= dh_r[DH_LBA_BIT];
			if (cmd_take) begin
				med_no_erase <= (bus.tf_wdata == OP_WS_NE)
					|| (bus.tf_wdata == OP_WM_NE); // RULE11 RULE19
				med_verify   <= (bus.tf_wdata == OP_WVER); // RULE20
			end
		end
	end

	assign bus.busy_flag         = busy_r;
	assign bus.data_request_flag = drq_r;
	assign bus.err_flag          = err_r;
	assign bus.abrt_flag         = abrt_r;
	assign bus.intrq             = intrq_r;
	assign bus.sec_cnt           = cnt_r;
	assign bus.sec_num           = snum_r;
	assign bus.cyl_lo            = cyll_r;
	assign bus.cyl_hi            = cylh_r;
	assign bus.drv_head          = dh_r;
endmodule : awce_dev

// ===== src/awce_host.sv
// host end: loads the task file, polls or waits, streams pio data
`timescale 1ns/1ps
module awce_host
	import awce_pkg::*;
(
	input  wire logic        sys_clk,   // 25 mhz clock
	input  wire logic        nrst,      // async reset, active low
	awce_if.host             bus,       // task-file link
	input  wire logic        cmd_go,    // pulse: start a command
	input  wire logic [7:0]  cmd_op,    // opcode
	input  wire logic [27:0] cmd_addr,  // lba or packed chs
	input  wire logic        cmd_lba,   // lba addressing
	input  wire logic [7:0]  cmd_cnt,   // sector count, 0 = 256
	input  wire logic [7:0]  blk_size,  // block size for block mode
	input  wire logic        src_valid, // data word offered
	input  wire logic [15:0] src_word,  // data word, ecc byte in [7:0]
	output logic             src_ready, // data word taken when both high
	output logic             hbusy,     // command in progress
	output logic             done,      // pulse: command ended
	output logic             fail       // last command ended in error
);
	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_TF   = 6'b000010,
		H_POLL = 6'b000100,
		H_XFER = 6'b001000,
		H_GAP  = 6'b010000,
		H_WAIT = 6'b100000
	} awce_hst_t;

	awce_hst_t   state_r;
	logic [7:0]  op_r;
	logic [27:0] addr_r;
	logic        lba_r;
	logic [7:0]  cnt_r;
	logic [2:0]  idx_r;
	logic [1:0]  hold_r;
	logic [8:0]  left_r;
	logic [8:0]  blk_r;
	logic [8:0]  word_r;
	logic        tf_wr_r;
	logic [2:0]  tf_addr_r;
	logic [7:0]  tf_wdata_r;
	logic        dat_wr_r;
	logic [15:0] dat_wdata_r;
	logic        st_rd_r;
	logic        is_long;
	logic        is_blk;
	logic        take;
	logic [8:0]  blk_sz;
	logic [8:0]  last_w;

	assign is_long = (op_r == OP_LONG_A) || (op_r == OP_LONG_B);
	assign is_blk  = (op_r == OP_WM) || (op_r == OP_WM_NE);
	assign blk_sz  = !is_blk ? ONE_SECT
		: ((left_r < {1'b0, blk_size}) ? left_r : {1'b0, blk_size});
	assign last_w  = is_long ? LAST_LONG : LAST_WORD;
	assign take    = src_ready && src_valid;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= H_IDLE;
			op_r <= 8'h00;
			addr_r <= 28'h0000000;
			lba_r <= 1'b0;
			cnt_r <= 8'h00;
			idx_r <= 3'h0;
			hold_r <= 2'h0;
			left_r <= 9'h000;
			blk_r <= 9'h000;
			word_r <= 9'h000;
			tf_wr_r <= 1'b0;
			tf_addr_r <= 3'h0;
			tf_wdata_r <= 8'h00;
			dat_wr_r <= 1'b0;
			dat_wdata_r <= 16'h0000;
			st_rd_r <= 1'b0;
			src_ready <= 1'b0;
			hbusy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
		end else begin
			tf_wr_r <= 1'b0;
			dat_wr_r <= 1'b0;
			st_rd_r <= 1'b0;
			src_ready <= 1'b0;
			done <= 1'b0;
			if (hold_r != 2'h0) begin
				hold_r <= hold_r - 2'h1;
			end
			case (state_r)
			H_IDLE: begin
				if (cmd_go) begin
					state_r <= H_TF;
					op_r <= cmd_op;
					addr_r <= cmd_addr;
					lba_r <= cmd_lba;
					cnt_r <= cmd_cnt;
					idx_r <= TF_CNT;
					hbusy <= 1'b1;
					fail <= 1'b0;
				end
			end
			H_TF: begin
				tf_wr_r <= 1'b1;
				tf_addr_r <= idx_r;
				idx_r <= idx_r + 3'h1;
				if (idx_r == TF_CNT) begin
					tf_wdata_r <= cnt_r;
				end else if (idx_r == TF_SNUM) begin
					tf_wdata_r <= addr_r[7:0]; // RULE23
				end else if (idx_r == TF_CYLL) begin
					tf_wdata_r <= addr_r[15:8];
				end else if (idx_r == TF_CYLH) begin
					tf_wdata_r <= addr_r[23:16];
				end else if (idx_r == TF_DH) begin
					// bits 7 and 5 read as one, bit 6 selects lba
					tf_wdata_r <= {1'b1, lba_r, 1'b1, 1'b0, addr_r[27:24]};
				end else begin
					tf_wdata_r <= op_r;
					state_r <= H_POLL;
					hold_r <= 2'h3;
					left_r <= is_long ? ONE_SECT
						: ((cnt_r == 8'h00) ? MAX_SECT : {1'b0, cnt_r});
				end
			end
			H_POLL: begin
				// no interrupt comes first, so poll; never send while busy
				if (hold_r == 2'h0) begin
					if (bus.err_flag && !bus.busy_flag) begin
						state_r <= H_IDLE;
						hbusy <= 1'b0;
						done <= 1'b1;
						fail <= 1'b1;
					end else if (!bus.busy_flag
						&& bus.data_request_flag) begin // RULE14 RULE15
						state_r <= H_XFER;
						blk_r <= blk_sz;
						word_r <= 9'h000;
					end
				end
			end
			H_XFER: begin
				// busy/request here only pace words, the block was qualified
				src_ready <= !take && !dat_wr_r && !bus.busy_flag
					&& bus.data_request_flag; // RULE15
				if (bus.err_flag && !bus.busy_flag) begin
					// a failing sector ends the command even in mid-block
					state_r <= H_IDLE; // RULE9
					st_rd_r <= 1'b1;
					hbusy <= 1'b0;
					done <= 1'b1;
					fail <= 1'b1;
				end else if (take) begin
					dat_wr_r <= 1'b1;
					dat_wdata_r <= (word_r > LAST_WORD)
						? {8'h00, src_word[7:0]} : src_word; // RULE2
					word_r <= word_r + 9'h001;
					if (word_r == last_w) begin
						word_r <= 9'h000;
						left_r <= left_r - ONE_SECT;
						blk_r <= blk_r - ONE_SECT;
						hold_r <= 2'h3;
						state_r <= (blk_r == ONE_SECT) ? H_WAIT : H_GAP;
					end
				end
			end
			H_GAP: begin
				if (hold_r == 2'h0) begin
					state_r <= H_XFER;
				end
			end
			H_WAIT: begin
				if ((hold_r == 2'h0) && bus.intrq && !st_rd_r) begin
					st_rd_r <= 1'b1;
					if (bus.err_flag) begin
						state_r <= H_IDLE;
						hbusy <= 1'b0;
						done <= 1'b1;
						fail <= 1'b1;
					end else if (bus.data_request_flag) begin
						state_r <= H_XFER; // RULE5
						blk_r <= blk_sz;
					end else begin
						state_r <= H_IDLE;
						hbusy <= 1'b0;
						done <= 1'b1;
					end
				end
			end
			default: state_r <= H_IDLE;
			endcase
		end
	end

	assign bus.tf_wr     = tf_wr_r;
	assign bus.tf_addr   = tf_addr_r;
	assign bus.tf_wdata  = tf_wdata_r;
	assign bus.dat_wr    = dat_wr_r;
	assign bus.dat_wdata = dat_wdata_r;
	assign bus.st_rd     = st_rd_r;
endmodule : awce_host

// ===== dv/awce_assertions.sv
// concurrent checks on the task-file link between host and device
`timescale 1ns/1ps
module awce_assertions
	import awce_pkg::*;
(
	input wire logic       sys_clk,           // clock
	input wire logic       nrst,              // async reset, active low
	input wire logic       tf_wr,             // task-file write strobe
	input wire logic [2:0] tf_addr,           // task-file offset
	input wire logic [7:0] tf_wdata,          // task-file data
	input wire logic       dat_wr,            // pio data strobe
	input wire logic       st_rd,             // status read
	input wire logic       busy_flag,         // device busy
	input wire logic       data_request_flag, // device data request
	input wire logic       err_flag,          // device error
	input wire logic       abrt_flag,         // aborted command
	input wire logic       intrq              // interrupt request
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	logic cmd_wr;
	logic blk_cmd;
	logic ws_cmd;
	// only a command written to an idle device is taken
	assign cmd_wr  = tf_wr && tf_addr == TF_CMD && !busy_flag
		&& !data_request_flag;
	assign blk_cmd = cmd_wr && (tf_wdata == OP_WM || tf_wdata == OP_WM_NE);
	assign ws_cmd  = cmd_wr && (tf_wdata == OP_WS_A || tf_wdata == OP_WS_B);

	////////////////////////////////////////////////////////////////////////
	a_busy_block: assert property (blk_cmd |-> ##1 (busy_flag || abrt_flag))
		else $error("busy late after block command");
	a_first_quiet: assert property (ws_cmd |-> ##1 busy_flag
		##1 (data_request_flag && !busy_flag && !$rose(intrq)))
		else $error("bad start of sector write");
	a_data_gated: assert property (dat_wr |-> data_request_flag && !busy_flag)
		else $error("data moved outside data request");
	a_sector_close: assert property ($fell(data_request_flag) |-> busy_flag)
		else $error("busy not set after sector");
	a_done_irq: assert property ($fell(busy_flag) && !data_request_flag
		|-> intrq) else $error("completion without interrupt");
	a_err_halts: assert property ($rose(err_flag)
		|-> (!busy_flag && !data_request_flag) [*4])
		else $error("transfer continues after error");
	a_abort_flags: assert property ($rose(abrt_flag)
		|-> err_flag && intrq && !busy_flag)
		else $error("abort flags incomplete");
	a_status_clears: assert property ((st_rd && !busy_flag
		&& !data_request_flag) |=> !intrq)
		else $error("interrupt not cleared by status read");

	c_block: cover property (blk_cmd ##1 busy_flag);
	c_abort: cover property ($rose(abrt_flag));
	c_media_err: cover property ($rose(err_flag) && !abrt_flag);
endmodule : awce_assertions

// ===== dv/tb.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module tb;
	import awce_pkg::*;
	logic        sys_clk, nrst, cmd_go, cmd_lba, src_valid, mult_en;
	logic        med_done, med_err, med_req, med_lba_mode, med_no_erase;
	logic        med_verify, wd_valid, src_ready, hbusy, done, fail;
	logic        is_long, irq_d, m_ne, m_vf, m_lba;
	logic [7:0]  cmd_op, cmd_cnt, blk_size, mult_size, msz;
	logic [27:0] cmd_addr, med_addr;
	logic [15:0] src_word, wd_data;
	logic [15:0] wq[$];
	logic [27:0] mq[$];
	logic [7:0]  ops[5] = '{OP_WS_B, OP_WS_NE, OP_WVER, OP_LONG_A, OP_LONG_B};
	int          n_fail, n_checks, n_irq, it, fail_at, mwait, cyc;

	awce_if link();
	awce_dev u_awce_dev (.sys_clk(sys_clk), .nrst(nrst), .bus(link),
		.mult_size(mult_size), .mult_en(mult_en), .med_req(med_req),
		.med_addr(med_addr), .med_lba_mode(med_lba_mode),
		.med_no_erase(med_no_erase), .med_verify(med_verify),
		.med_done(med_done), .med_err(med_err), .wd_valid(wd_valid),
		.wd_data(wd_data));
	awce_host u_awce_host (.sys_clk(sys_clk), .nrst(nrst), .bus(link),
		.cmd_go(cmd_go), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_lba(cmd_lba), .cmd_cnt(cmd_cnt), .blk_size(blk_size),
		.src_valid(src_valid), .src_word(src_word), .src_ready(src_ready),
		.hbusy(hbusy), .done(done), .fail(fail));
	awce_assertions u_awce_assertions (.sys_clk(sys_clk), .nrst(nrst),
		.tf_wr(link.tf_wr), .tf_addr(link.tf_addr), .tf_wdata(link.tf_wdata),
		.dat_wr(link.dat_wr), .st_rd(link.st_rd), .busy_flag(link.busy_flag),
		.data_request_flag(link.data_request_flag), .err_flag(link.err_flag),
		.abrt_flag(link.abrt_flag), .intrq(link.intrq));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	// source, sink and media; media answers a few cycles after each request
	always @(posedge sys_clk) begin
		if (src_valid && src_ready) begin
			// ecc bytes of a long write are not expected at the sink
			if (!(is_long && it >= SECT_WORDS)) wq.push_back(src_word);
			it++;
			src_word <= src_word + 16'h3c5b;
		end
		if (wd_valid) begin
			chk(wq.size() > 0 && wd_data === wq[0], "data word");
			if (wq.size() > 0) void'(wq.pop_front());
		end
		irq_d <= link.intrq;
		if (link.intrq && !irq_d) n_irq++;
		med_done <= 1'b0;
		med_err  <= 1'b0;
		if (med_req) begin
			mq.push_back(med_addr);
			{m_ne, m_vf, m_lba} <= {med_no_erase, med_verify, med_lba_mode};
			mwait <= 6;
		end else if (mwait == 1) begin
			med_done <= 1'b1;
			med_err  <= (mq.size() - 1 == fail_at);
			mwait    <= 0;
		end else if (mwait > 1) begin
			mwait <= mwait - 1;
		end
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			$display("unexpected at %0t: run too long", $time);
			summarize();
		end
	end

	task automatic go(input logic [7:0] op, input logic [27:0] a,
		input logic lba, input logic [7:0] cnt, input logic [7:0] bs,
		input logic men, input int fa);
		mq.delete();
		n_irq = 0;
		it = 0;
		fail_at = fa;
		is_long = (op == OP_LONG_A || op == OP_LONG_B);
		@(posedge sys_clk);
		{cmd_op, cmd_addr, cmd_lba, cmd_cnt} <= {op, a, lba, cnt};
		{blk_size, mult_size, mult_en} <= {bs, bs, men};
		cmd_go <= 1'b1;
		@(posedge sys_clk);
		cmd_go <= 1'b0;
		do @(negedge sys_clk); while (done !== 1'b1);
	endtask : go

	task automatic expect_run(input logic [27:0] a, input int ns, input int ni,
		input logic f, input logic ne, input logic vf, input logic lba);
		chk(mq.size() == ns, "sector count");
		foreach (mq[k]) chk(mq[k] === a + 28'(k), "sector address");
		if (ni >= 0) chk(n_irq == ni, "interrupt count");
		chk(fail === f, "end status");
		chk(hbusy === 1'b0, "host still busy");
		chk(wq.size() == 0, "words missing");
		if (ns > 0) chk({m_ne, m_vf, m_lba} === {ne, vf, lba}, "media mode");
		$display("test of opcode %h done", cmd_op);
	endtask : expect_run

	////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, cmd_go, cmd_lba, src_valid, mult_en, med_done, med_err} = '0;
		{cmd_op, cmd_cnt, blk_size, mult_size, cmd_addr} = '0;
		{is_long, irq_d, m_ne, m_vf, m_lba} = '0;
		{n_fail, n_checks, n_irq, it, mwait, cyc} = '0;
		src_word = 16'h1357;
		fail_at = -1;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		src_valid <= 1'b1;
		go(OP_WS_A, 28'h1234567, 1'b1, 8'h02, 8'h01, 1'b1, -1);
		expect_run(28'h1234567, 2, 2, 0, 0, 0, 1);
		foreach (ops[i]) begin
			go(ops[i], 28'h0a01203, i[0], 8'h01, 8'h01, 1'b1, -1);
			expect_run(28'h0a01203, 1, 1, 0, ops[i] == OP_WS_NE,
				ops[i] == OP_WVER, i[0]);
		end
		go(OP_WM, 28'h0000ffe, 1'b1, 8'h05, 8'h02, 1'b1, -1);
		expect_run(28'h0000ffe, 5, 3, 0, 0, 0, 1);
		go(OP_WM_NE, 28'h00abcde, 1'b1, 8'h01, 8'h01, 1'b1, -1);
		expect_run(28'h00abcde, 1, 1, 0, 1, 0, 1);
		// chs: last sector of the track on the last head wraps the cylinder
		go(OP_WS_A, 28'hf00123f, 1'b0, 8'h01, 8'h01, 1'b1, -1);
		expect_run(28'hf00123f, 1, 1, 0, 0, 0, 0);
		chk({link.drv_head[3:0], link.cyl_hi, link.cyl_lo,
			link.sec_num} === 28'h0001301, "chs advance");
		// zero count runs on past one sector; residual shows 256 - 1
		go(OP_WS_A, 28'h0000100, 1'b1, 8'h00, 8'h01, 1'b1, 1);
		expect_run(28'h0000100, 2, 2, 1, 0, 0, 1);
		chk(link.sec_cnt === 8'hff, "zero count residual");
		go(OP_WM, 28'h0fffffe, 1'b1, 8'h08, 8'h04, 1'b1, 2);
		expect_run(28'h0fffffe, 3, 1, 1, 0, 0, 1);
		chk(link.err_flag === 1'b1, "error flag");
		chk(link.sec_cnt === 8'h06, "residual count");
		chk({link.drv_head[3:0], link.cyl_hi, link.cyl_lo,
			link.sec_num} === 28'h1000000, "failing address");
		for (int j = 0; j < 2; j++) begin
			msz = (j == 0) ? 8'h02 : 8'h00;
			go(OP_WM, 28'h0000010, 1'b1, 8'h02, msz, j == 1, -1);
			expect_run(28'h0000010, 0, -1, 1, 0, 0, 1);
			chk(link.abrt_flag === 1'b1, "abort flag");
		end
		summarize();
	end
endmodule : tb
